// >>> core/bcf_pkg.sv
package bcf_pkg;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] REG_CMD_WORD = 16'h0001;
  localparam logic [15:0] REG_SPEED_SET = 16'h0002;
  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_REV_BIT = 1;
  localparam int CMD_EXTF_BIT = 4;
  localparam int CMD_FRST_BIT = 5;
  localparam int CMD_GIN_LSB = 12;
  localparam logic [15:0] CMD_USED_MASK = 16'hF033;
  localparam logic [15:0] FREQ_FULL_SCALE = 16'h7530;
  localparam logic [15:0] FREQ_RESET = 16'h0000;
  localparam logic [15:0] FC_NONE = 16'h0000;
  localparam logic [15:0] FC_UV_MAIN = 16'h0002;
  localparam logic [15:0] FC_UV_CTRL = 16'h0003;
  localparam logic [15:0] FC_UV_CHARGE = 16'h0004;
  localparam logic [15:0] FC_SHORT = 16'h0005;
  localparam logic [15:0] FC_GROUND = 16'h0006;
  localparam logic [15:0] FC_OVERCUR = 16'h0007;
  localparam logic [15:0] FC_OVERVOLT = 16'h0008;
  localparam logic [15:0] FC_EXT_BASE = 16'h0011;
  localparam logic [5:0] EXT_TERM_LAST = 6'h05;
  localparam logic [15:0] FC_SER_LOSS = 16'h0021;
  localparam logic [15:0] FC_OPT_LOSS = 16'h0022;
  localparam logic [15:0] FC_HW = 16'h0030;
  localparam logic [15:0] FC_SELF_BASE = 16'h0083;
  localparam logic [5:0] SELF_LAST = 6'h2B;
  localparam logic [15:0] FC_WATCHDOG = 16'h008E;
  localparam logic [15:0] FC_CLOCK = 16'h0091;
  typedef enum logic [3:0] {
    FK_UV_MAIN = 4'h0,
    FK_UV_CTRL = 4'h1,
    FK_UV_CHARGE = 4'h2,
    FK_SHORT = 4'h3,
    FK_GROUND = 4'h4,
    FK_OVERCUR = 4'h5,
    FK_OVERVOLT = 4'h6,
    FK_EXT_TERM = 4'h7,
    FK_SER_LOSS = 4'h8,
    FK_OPT_LOSS = 4'h9,
    FK_HW = 4'hA,
    FK_SELF_CHECK = 4'hB,
    FK_WATCHDOG = 4'hC,
    FK_CLOCK = 4'hD
  } bcf_fault_kind_t;
endpackage

// >>> core/bcf_fault_enc.sv
`timescale 1ns/1ps
module bcf_fault_enc (
  input wire bcf_pkg::bcf_fault_kind_t kind_i,
  input wire logic [5:0] detail_i,
  output logic [15:0] code_o,
  output logic valid_o
);
  import bcf_pkg::*;
  always_comb begin
    code_o = FC_NONE;
    valid_o = 1'b1;
    case (kind_i)
      FK_UV_MAIN: code_o = FC_UV_MAIN;
      FK_UV_CTRL: code_o = FC_UV_CTRL;
      FK_UV_CHARGE: code_o = FC_UV_CHARGE;
      FK_SHORT: code_o = FC_SHORT;
      FK_GROUND: code_o = FC_GROUND;
      FK_OVERCUR: code_o = FC_OVERCUR;
      FK_OVERVOLT: code_o = FC_OVERVOLT;
      FK_EXT_TERM: begin
        // detail counts terminals from zero upward, five at most
        if (detail_i <= EXT_TERM_LAST) begin
          code_o = FC_EXT_BASE + {10'h000, detail_i};
        end else begin
          valid_o = 1'b0;
        end
      end
      FK_SER_LOSS: code_o = FC_SER_LOSS;
      FK_OPT_LOSS: code_o = FC_OPT_LOSS;
      FK_HW: code_o = FC_HW;
      FK_SELF_CHECK: begin
        if (detail_i <= SELF_LAST) begin
          code_o = FC_SELF_BASE + {10'h000, detail_i};
        end else begin
          valid_o = 1'b0;
        end
      end
      FK_WATCHDOG: code_o = FC_WATCHDOG;
      FK_CLOCK: code_o = FC_CLOCK;
      default: valid_o = 1'b0;
    endcase
  end
endmodule

// >>> core/bcf_top.sv
`timescale 1ns/1ps
module bcf_top #(
  parameter int HIST_DEPTH = 4
) (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] OWN_ADDR_I,
  input wire logic WR_VALID_I,
  input wire logic [7:0] WR_SLAVE_ADDR_I,
  input wire logic [15:0] WR_REG_ADDR_I,
  input wire logic [15:0] WR_DATA_I,
  input wire logic FAULT_EVENT_I,
  input wire bcf_pkg::bcf_fault_kind_t FAULT_KIND_I,
  input wire logic [5:0] FAULT_DETAIL_I,
  input wire logic [$clog2(HIST_DEPTH)-1:0] HIST_IDX_I,
  output logic RUN_O,
  output logic REVERSE_O,
  output logic EXT_FAULT_O,
  output logic FAULT_RESET_O,
  output logic [3:0] GENERAL_INPUT_O,
  output logic [15:0] FREQ_REF_O,
  output logic BROADCAST_O,
  output logic REPLY_O,
  output logic REPLY_ERR_O,
  output logic [15:0] HIST_CODE_O
);
  import bcf_pkg::*;

  // the shift by concatenation needs two entries, the index a power of two
  localparam bit DEPTH_BAD = HIST_DEPTH < 2
    || (HIST_DEPTH & (HIST_DEPTH - 1)) != 0;
  if (DEPTH_BAD) begin : g_depth_chk
    $error("HIST_DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic run;
    logic rev;
    logic extf;
    logic frst;
    logic [3:0] gin;
    logic [15:0] freq;
    logic bcast;
    logic reply;
    logic reply_err;
    logic [HIST_DEPTH-1:0][15:0] hist;
    logic [15:0] hout;
  } bcf_state_t;

  bcf_state_t s_q;
  bcf_state_t s_d;
  logic [15:0] enc_code;
  logic enc_vld;

  bcf_fault_enc u_enc (
    .kind_i(FAULT_KIND_I),
    .detail_i(FAULT_DETAIL_I),
    .code_o(enc_code),
    .valid_o(enc_vld)
  );

  function automatic logic [15:0] clamp_freq(input logic [15:0] v);
    // values past full scale are held at 100 percent
    return (v > FREQ_FULL_SCALE) ? FREQ_FULL_SCALE : v;
  endfunction

  logic is_bcast;
  logic is_mine;
  logic hit_cmd;
  logic hit_spd;
  logic [15:0] cmd_used;
  assign is_bcast = WR_VALID_I && (WR_SLAVE_ADDR_I == BCAST_ADDR);
  assign is_mine = WR_VALID_I && !is_bcast && (WR_SLAVE_ADDR_I == OWN_ADDR_I);
  assign hit_cmd = WR_REG_ADDR_I == REG_CMD_WORD;
  assign hit_spd = WR_REG_ADDR_I == REG_SPEED_SET;
  assign cmd_used = WR_DATA_I & CMD_USED_MASK;

  always_comb begin
    s_d = s_q;
    s_d.frst = 1'b0;
    s_d.bcast = is_bcast;
    // broadcasts never request a reply, not even an error one
    s_d.reply = is_mine;
    s_d.reply_err = is_mine && !hit_cmd && !hit_spd;
    if ((is_bcast || is_mine) && hit_cmd) begin
      s_d.run = cmd_used[CMD_RUN_BIT];
      s_d.rev = cmd_used[CMD_REV_BIT];
      s_d.extf = cmd_used[CMD_EXTF_BIT];
      s_d.frst = cmd_used[CMD_FRST_BIT];
      s_d.gin = cmd_used[CMD_GIN_LSB +: 4];
    end
    if ((is_bcast || is_mine) && hit_spd) begin
      s_d.freq = clamp_freq(WR_DATA_I);
    end
    if (FAULT_EVENT_I && enc_vld) begin
      // newest entry at index 0, oldest falls off the end
      s_d.hist = {s_q.hist[HIST_DEPTH-2:0], enc_code};
    end
    s_d.hout = s_q.hist[HIST_IDX_I];
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      s_q <= '0;
      s_q.freq <= FREQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign RUN_O = s_q.run;
  assign REVERSE_O = s_q.rev;
  assign EXT_FAULT_O = s_q.extf;
  assign FAULT_RESET_O = s_q.frst;
  assign GENERAL_INPUT_O = s_q.gin;
  assign FREQ_REF_O = s_q.freq;
  assign BROADCAST_O = s_q.bcast;
  assign REPLY_O = s_q.reply;
  assign REPLY_ERR_O = s_q.reply_err;
  assign HIST_CODE_O = s_q.hout;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_bcast_cmd;
    WR_VALID_I && WR_SLAVE_ADDR_I == 8'h00 && WR_REG_ADDR_I == 16'h0001;
  endsequence

  property p_bcast_taken;
    WR_VALID_I && WR_SLAVE_ADDR_I == 8'h00 |=> BROADCAST_O;
  endproperty
  a_bcast_taken: assert property (p_bcast_taken)
    else $error("broadcast frame not taken");

  property p_bcast_silent;
    WR_VALID_I && WR_SLAVE_ADDR_I == 8'h00 |=> !REPLY_O && !REPLY_ERR_O;
  endproperty
  a_bcast_silent: assert property (p_bcast_silent)
    else $error("reply raised for a broadcast");

  property p_run_dir;
    s_bcast_cmd |=> RUN_O == $past(WR_DATA_I[0])
      && REVERSE_O == $past(WR_DATA_I[1]);
  endproperty
  a_run_dir: assert property (p_run_dir)
    else $error("run or direction does not follow command word");

  property p_fault_bits;
    s_bcast_cmd |=> EXT_FAULT_O == $past(WR_DATA_I[4])
      && FAULT_RESET_O == $past(WR_DATA_I[5]) ##1 !FAULT_RESET_O
      || $past(WR_VALID_I);
  endproperty
  a_fault_bits: assert property (p_fault_bits)
    else $error("fault bits wrong or reset not a pulse");

  property p_gin;
    s_bcast_cmd |=> GENERAL_INPUT_O == $past(WR_DATA_I[15:12]);
  endproperty
  a_gin: assert property (p_gin)
    else $error("general inputs do not follow bits C to F");

  property p_reserved;
    WR_VALID_I && WR_REG_ADDR_I != 16'h0001 |=> $stable(RUN_O)
      && $stable(GENERAL_INPUT_O) && $stable(EXT_FAULT_O);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("command outputs moved without a command write");

  property p_freq;
    WR_VALID_I && (WR_SLAVE_ADDR_I == 8'h00) && WR_REG_ADDR_I == 16'h0002
      |=> FREQ_REF_O == (($past(WR_DATA_I) > 16'h7530) ? 16'h7530
      : $past(WR_DATA_I));
  endproperty
  a_freq: assert property (p_freq)
    else $error("setpoint not stored at full-scale 30000");

  property p_hist;
    FAULT_EVENT_I && enc_vld && HIST_IDX_I == '0 ##1 HIST_IDX_I == '0
      |=> HIST_CODE_O == $past(enc_code, 2);
  endproperty
  a_hist: assert property (p_hist)
    else $error("newest history entry is not the recorded code");

  property p_ext_code;
    FAULT_KIND_I == FK_EXT_TERM && FAULT_DETAIL_I <= 6'h05
      |-> enc_vld && enc_code == 16'h0011 + {10'h000, FAULT_DETAIL_I};
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("external fault code out of sequence");

  property p_self_code;
    FAULT_KIND_I == FK_SELF_CHECK && enc_vld
      |-> enc_code >= 16'h0083 && enc_code <= 16'h00AE;
  endproperty
  a_self_code: assert property (p_self_code)
    else $error("self-check code outside its range");

  property p_uv_code;
    FAULT_KIND_I == FK_UV_CTRL |-> enc_vld && enc_code == 16'h0003;
  endproperty
  a_uv_code: assert property (p_uv_code)
    else $error("control supply undervoltage code wrong");

  property p_power_code;
    FAULT_KIND_I == FK_OVERVOLT |-> enc_vld && enc_code == 16'h0008;
  endproperty
  a_power_code: assert property (p_power_code)
    else $error("overvoltage code wrong");

  property p_link_code;
    FAULT_KIND_I == FK_OPT_LOSS |-> enc_vld && enc_code == 16'h0022;
  endproperty
  a_link_code: assert property (p_link_code)
    else $error("option link loss code wrong");

  property p_hw_code;
    FAULT_KIND_I == FK_HW |-> enc_vld && enc_code == 16'h0030;
  endproperty
  a_hw_code: assert property (p_hw_code)
    else $error("hardware fault summary code wrong");

  // a refused fault must not push an empty slot into the history
  property p_hist_refused;
    FAULT_EVENT_I && !enc_vld |=> $stable(s_q.hist);
  endproperty
  a_hist_refused: assert property (p_hist_refused)
    else $error("history moved on a refused fault");
endmodule

// >>> testbench/bcf_master_model.sv
`timescale 1ns/1ps
module bcf_master_model (
  input wire logic clk_i,
  output logic wr_valid_o,
  output logic [7:0] wr_slave_addr_o,
  output logic [15:0] wr_reg_addr_o,
  output logic [15:0] wr_data_o
);
  initial begin
    wr_valid_o = 1'b0;
    wr_slave_addr_o = 8'hFF;
    wr_reg_addr_o = 16'hFFFF;
    wr_data_o = 16'h0000;
  end
  // idle lines carry the inverse so a stale frame is never reused
  task automatic wr(input logic [7:0] sa, input logic [15:0] ra,
                    input logic [15:0] d);
    @(posedge clk_i);
    wr_valid_o <= 1'b1;
    wr_slave_addr_o <= sa;
    wr_reg_addr_o <= ra;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_valid_o <= 1'b0;
    wr_slave_addr_o <= ~sa;
    wr_reg_addr_o <= ~ra;
    wr_data_o <= ~d;
  endtask
endmodule

// >>> testbench/bcf_top_tb_top.sv
`timescale 1ns/1ps
module bcf_top_tb_top;
  import bcf_pkg::*;
  logic clk, rst, wv, fev, run, rev, extf, frst, bc, rp, rpe;
  logic [7:0] wsa;
  logic [15:0] wra, wd, freq, hcode;
  logic [5:0] fd;
  logic [1:0] hidx;
  logic [3:0] gin;
  bcf_fault_kind_t fk;
  int err_total, n_tests, cyc;
  bcf_fault_kind_t fks[16] = '{FK_UV_MAIN, FK_UV_CTRL, FK_UV_CHARGE,
    FK_SHORT, FK_GROUND, FK_OVERCUR, FK_OVERVOLT, FK_EXT_TERM, FK_EXT_TERM,
    FK_SER_LOSS, FK_OPT_LOSS, FK_HW, FK_SELF_CHECK, FK_SELF_CHECK,
    FK_WATCHDOG, FK_CLOCK};
  logic [5:0] fds[16] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
    6'h00, 6'h05, 6'h00, 6'h00, 6'h00, 6'h00, 6'h2B, 6'h00, 6'h00};
  logic [15:0] fcs[16] = '{16'h0002, 16'h0003, 16'h0004, 16'h0005,
    16'h0006, 16'h0007, 16'h0008, 16'h0011, 16'h0016, 16'h0021, 16'h0022,
    16'h0030, 16'h0083, 16'h00AE, 16'h008E, 16'h0091};
  bcf_master_model m (.clk_i(clk), .wr_valid_o(wv), .wr_slave_addr_o(wsa),
    .wr_reg_addr_o(wra), .wr_data_o(wd));
  bcf_top #(.HIST_DEPTH(4)) dut_u (.REF_CLK_I(clk), .SYS_RST_I(rst),
    .OWN_ADDR_I(8'h05), .WR_VALID_I(wv), .WR_SLAVE_ADDR_I(wsa),
    .WR_REG_ADDR_I(wra), .WR_DATA_I(wd), .FAULT_EVENT_I(fev),
    .FAULT_KIND_I(fk), .FAULT_DETAIL_I(fd), .HIST_IDX_I(hidx),
    .RUN_O(run), .REVERSE_O(rev), .EXT_FAULT_O(extf),
    .FAULT_RESET_O(frst), .GENERAL_INPUT_O(gin), .FREQ_REF_O(freq),
    .BROADCAST_O(bc), .REPLY_O(rp), .REPLY_ERR_O(rpe), .HIST_CODE_O(hcode));
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // c = {run, reverse, ext fault, fault reset, inputs}, p = pulses
  task automatic outs(input logic [7:0] c, input logic [2:0] p);
    chk({8'h00, run, rev, extf, frst, gin}, {8'h00, c});
    chk({13'h0000, bc, rp, rpe}, {13'h0000, p});
  endtask
  task automatic flt(input bcf_fault_kind_t k, input logic [5:0] d);
    @(posedge clk);
    fev <= 1'b1;
    fk <= k;
    fd <= d;
    hidx <= 2'h0;
    @(posedge clk);
    fev <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    fev = 1'b0;
    fk = FK_UV_MAIN;
    fd = 6'h00;
    hidx = 2'h0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    outs(8'h00, 3'b000);
    chk(freq, 16'h0000);
    chk(hcode, 16'h0000);
    $display("test reset done");
    m.wr(8'h00, 16'h0001, 16'h1021);
    #1;
    outs(8'h91, 3'b100);
    @(posedge clk);
    #1;
    outs(8'h81, 3'b000);
    m.wr(8'h00, 16'h0001, 16'h0FDE);
    #1;
    outs(8'h60, 3'b100);
    for (int i = 0; i < 4; i++) begin
      m.wr(8'h00, 16'h0001, 16'h1000 << i);
      #1;
      outs(8'h01 << i, 3'b100);
    end
    $display("test command word done");
    m.wr(8'h00, 16'h0002, 16'h7530);
    #1;
    chk(freq, 16'h7530);
    m.wr(8'h00, 16'h0002, 16'h7531);
    #1;
    chk(freq, 16'h7530);
    m.wr(8'h00, 16'h0002, 16'h1234);
    #1;
    chk(freq, 16'h1234);
    $display("test setpoint done");
    m.wr(8'h06, 16'h0001, 16'h0001);
    #1;
    outs(8'h08, 3'b000);
    m.wr(8'h00, 16'h0003, 16'h0001);
    #1;
    outs(8'h08, 3'b100);
    m.wr(8'h05, 16'h0003, 16'h0001);
    #1;
    outs(8'h08, 3'b011);
    m.wr(8'h05, 16'h0001, 16'h0001);
    #1;
    outs(8'h80, 3'b010);
    $display("test addressing done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    outs(8'h00, 3'b000);
    chk(freq, 16'h0000);
    chk(hcode, 16'h0000);
    $display("test mid-run reset done");
    for (int i = 0; i < 16; i++) begin
      flt(fks[i], fds[i]);
      chk(hcode, fcs[i]);
    end
    flt(FK_EXT_TERM, 6'h06);
    chk(hcode, 16'h0091);
    for (int i = 1; i < 4; i++) begin
      @(posedge clk);
      hidx <= i[1:0];
      @(posedge clk);
      #1;
      chk(hcode, fcs[15-i]);
    end
    $display("test fault history done");
    final_report();
  end
endmodule
